// ==== rtl/pwm_output_defines.vh ====
/*
   Register offsets, field positions and reset values of the PWM output stage.
   Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef PWM_OUTPUT_DEFINES_VH
`define PWM_OUTPUT_DEFINES_VH

// Byte offsets on the APB
`define OFF_CONFIG   8'h00
`define OFF_CTRL     8'h04
`define OFF_OVERRIDE 8'h08
`define OFF_MAP      8'h0C
`define OFF_FCTRL    8'h10
`define OFF_FSTAT    8'h14
`define OFF_PINS     8'h18

// Write-once configuration
`define CFG_TOP_NEG  0
`define CFG_BOT_NEG  1
`define CFG_LOCKED   2

// Control register
`define CTL_EN       0
`define CTL_COMPL    1
`define CTL_SOFT_X   2
`define CTL_SOFT_Y   3
`define CTL_DT_LSB   8

// Override register
`define OVR_BITS_LSB 0
`define OVR_ENABLE   6

// Disable map: bank X outputs in [5:0], bank Y outputs in [11:6]
`define MAP_X_LSB    0
`define MAP_Y_LSB    6
`define MAP_LOCKED   12

// Fault control and status
`define FC_MODE_LSB  0
`define FC_INT_LSB   4
`define FS_PIN_LSB   0
`define FS_FLAG_LSB  4
`define FS_ACK_LSB   8

// Reset values
`define RST_MAP      12'hFFF
`define RST_DT       8'h00

`endif

// ==== rtl/fault_filter.v ====
/*
   Fault pin synchroniser and glitch filter for one fault input.
   Assumes an asynchronous pin and the CPU bus clock; reset is async high.
*/
`default_nettype none

module fault_filter (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Raw pin
   input  wire pin_i,
   // Filtered results
   output reg  level_o,
   output wire state_o,
   output reg  rise_o
);

   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_ARMED = 5'h02;
   localparam [4:0] S_H1    = 5'h04;
   localparam [4:0] S_HIGH  = 5'h08;
   localparam [4:0] S_L1    = 5'h10;

   reg       sync1_q;
   reg [4:0] state_q;
   reg [4:0] state_d;

   // Only the second stage is looked at; level_o is that second stage
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         level_o <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         level_o <= sync1_q;
      end
   end

   // One low sample arms the filter, two high samples confirm a fault
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE:  if (!level_o) state_d = S_ARMED;
         S_ARMED: if (level_o) state_d = S_H1;
         S_H1:    state_d = level_o ? S_HIGH : S_ARMED;
         S_HIGH:  if (!level_o) state_d = S_L1;
         S_L1:    state_d = level_o ? S_HIGH : S_ARMED;
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         rise_o  <= 1'b0;
      end else begin
         state_q <= state_d;
         rise_o  <= (state_q == S_H1) & level_o;
      end
   end

   // Stays set through the first low sample, clears after the second
   assign state_o = (state_q == S_HIGH) | (state_q == S_L1);

endmodule

`default_nettype wire

// ==== rtl/pwm_output_stage.v ====
/*
   Output stage of a six-channel motor PWM: polarity, software override with
   dead-time, two-bank fault and software disable, fault flags and requests.
   Assumes a PWM generator on the same clock that gives active-high channel
   levels and a one-cycle pulse at each PWM cycle start, and an APB master.
*/
// The implementer's own choices: the register offsets and the APB slave port.
`include "pwm_output_defines.vh"
`default_nettype none

module pwm_output_stage (
   // Clock and reset
   input  wire        MCLK_I,
   input  wire        RESET_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [7:0]  PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg         PREADY_O,
   output reg  [31:0] PRDATA_O,
   output reg         PSLVERR_O,
   // PWM generator side
   input  wire [5:0]  GEN_ACTIVE_I,
   input  wire        CYCLE_START_I,
   output reg         PWM_ENABLE_O,
   // Drive side
   input  wire [3:0]  FAULT_I,
   output reg  [5:0]  PWM_O,
   output reg  [5:0]  PWM_OE_O,
   output reg  [3:0]  FAULT_IRQ_O
);

   reg         top_neg_q;
   reg         bot_neg_q;
   reg         cfg_lock_q;
   reg         compl_q;
   reg         soft_x_bit_q;
   reg         soft_y_bit_q;
   reg  [7:0]  dead_q;
   reg  [5:0]  ovr_bits_q;
   reg         ovr_en_q;
   reg         src_ovr_q;
   reg  [11:0] map_q;
   reg         map_lock_q;
   reg  [3:0]  auto_mode_q;
   reg  [3:0]  irq_en_q;
   reg  [3:0]  flag_q;
   reg  [3:0]  fdis_q;
   reg         soft_x_q;
   reg         soft_y_q;
   reg  [6:0]  sel_q;
   reg  [31:0] rdata_d;
   reg  [6:0]  sel_d;

   wire [3:0]  level;
   wire [3:0]  pin_state;
   wire [3:0]  rise;
   wire [5:0]  cmp_act;
   wire [5:0]  act_d;
   wire [5:0]  out_dis;
   wire [5:0]  neg_mask;
   wire        bank_x;
   wire        bank_y;
   wire        boundary;
   wire        setup;
   wire        wr;
   wire [3:0]  ack;

   assign setup = PSEL_I & ~PENABLE_I;
   assign wr    = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
   assign ack   = (wr & sel_q[5]) ? PWDATA_I[`FS_ACK_LSB +: 4] : 4'h0;

   // Address decode in the setup cycle; the access phase then ends at once
   always @* begin
      rdata_d = 32'h0;
      sel_d   = 7'h00;
      if (PADDR_I == `OFF_CONFIG) begin
         sel_d   = 7'h01;
         rdata_d = {29'h0, cfg_lock_q, bot_neg_q, top_neg_q};
      end else if (PADDR_I == `OFF_CTRL) begin
         sel_d   = 7'h02;
         rdata_d = {16'h0, dead_q, 4'h0, soft_y_bit_q, soft_x_bit_q, compl_q, PWM_ENABLE_O};
      end else if (PADDR_I == `OFF_OVERRIDE) begin
         sel_d   = 7'h04;
         rdata_d = {25'h0, ovr_en_q, ovr_bits_q};
      end else if (PADDR_I == `OFF_MAP) begin
         sel_d   = 7'h08;
         rdata_d = {19'h0, map_lock_q, map_q};
      end else if (PADDR_I == `OFF_FCTRL) begin
         sel_d   = 7'h10;
         rdata_d = {24'h0, irq_en_q, auto_mode_q};
      end else if (PADDR_I == `OFF_FSTAT) begin
         sel_d   = 7'h20;
         rdata_d = {24'h0, flag_q, pin_state};
      end else if (PADDR_I == `OFF_PINS) begin
         sel_d   = 7'h40;
         rdata_d = {20'h0, out_dis, PWM_O};
      end
   end

   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0;
         sel_q     <= 7'h00;
      end else begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup & (sel_d == 7'h00);
         PRDATA_O  <= (setup & ~PWRITE_I) ? rdata_d : 32'h0;
         sel_q     <= setup ? sel_d : 7'h00;
      end
   end

   // High on the access edge of a write to the register behind select bit idx
   function wr_hit;
      input       strobe;
      input [6:0] sel;
      input [2:0] idx;
      begin
         wr_hit = strobe & sel[idx];
      end
   endfunction

   // Write-once, so a stray write cannot flip polarity under a running drive
   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         top_neg_q  <= 1'b0;
         bot_neg_q  <= 1'b0;
         cfg_lock_q <= 1'b0;
      end else if (wr_hit(wr, sel_q, 3'h0) & ~cfg_lock_q) begin
         top_neg_q  <= PWDATA_I[`CFG_TOP_NEG];
         bot_neg_q  <= PWDATA_I[`CFG_BOT_NEG];
         cfg_lock_q <= 1'b1;
      end
   end

   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PWM_ENABLE_O <= 1'b0;
         compl_q      <= 1'b0;
         soft_x_bit_q <= 1'b0;
         soft_y_bit_q <= 1'b0;
         dead_q       <= `RST_DT;
      end else if (wr_hit(wr, sel_q, 3'h1)) begin
         PWM_ENABLE_O <= PWDATA_I[`CTL_EN];
         compl_q      <= PWDATA_I[`CTL_COMPL];
         soft_x_bit_q <= PWDATA_I[`CTL_SOFT_X];
         soft_y_bit_q <= PWDATA_I[`CTL_SOFT_Y];
         dead_q       <= PWDATA_I[`CTL_DT_LSB +: 8];
      end
   end

   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ovr_bits_q <= 6'h00;
         ovr_en_q   <= 1'b0;
      end else if (wr_hit(wr, sel_q, 3'h2)) begin
         ovr_bits_q <= PWDATA_I[`OVR_BITS_LSB +: 6];
         ovr_en_q   <= PWDATA_I[`OVR_ENABLE];
      end
   end

   // Locked too: a fault must not be rerouted away from its outputs later
   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         map_q      <= `RST_MAP;
         map_lock_q <= 1'b0;
      end else if (wr_hit(wr, sel_q, 3'h3) & ~map_lock_q) begin
         map_q      <= PWDATA_I[11:0];
         map_lock_q <= 1'b1;
      end
   end

   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         auto_mode_q <= 4'h0;
         irq_en_q    <= 4'h0;
      end else if (wr_hit(wr, sel_q, 3'h4)) begin
         auto_mode_q <= PWDATA_I[`FC_MODE_LSB +: 4];
         irq_en_q    <= PWDATA_I[`FC_INT_LSB +: 4];
      end
   end

   // Override takes the pins at once, hands them back at a cycle start.
   // The generator is not stopped here; only its path to the pins is.
   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         src_ovr_q <= 1'b0;
      end else if (ovr_en_q) begin
         src_ovr_q <= 1'b1;
      end else if (CYCLE_START_I) begin
         src_ovr_q <= 1'b0;
      end
   end

   // Under override there is no PWM cycle, so faults may clear every cycle
   assign boundary = CYCLE_START_I | ovr_en_q;

   // Dead-time per complementary pair, driven by the top source
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_pair
         reg  [7:0] cnt_q;
         reg        prev_q;
         wire       din;
         wire       quiet;
         assign din = src_ovr_q ? ovr_bits_q[2*p] : GEN_ACTIVE_I[2*p];
         always @(posedge MCLK_I or posedge RESET_I) begin
            if (RESET_I) begin
               cnt_q  <= 8'h00;
               prev_q <= 1'b0;
            end else begin
               prev_q <= din;
               if (din != prev_q) begin
                  cnt_q <= dead_q;
               end else if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         end
         // Both sides held off on the toggle cycle and while counting
         assign quiet = (cnt_q == 8'h00) & (din == prev_q);
         assign cmp_act[2*p] = din & quiet;
         // Odd bit only gates the bottom side, so it needs no dead-time
         assign cmp_act[2*p+1] = ~din & quiet & (~src_ovr_q | ovr_bits_q[2*p+1]);
      end
   endgenerate

   // Software disable holds until the bit is cleared and a cycle starts or override is on
   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         soft_x_q <= 1'b0;
         soft_y_q <= 1'b0;
      end else begin
         if (soft_x_bit_q) begin
            soft_x_q <= 1'b1;
         end else if (boundary) begin
            soft_x_q <= 1'b0;
         end
         if (soft_y_bit_q) begin
            soft_y_q <= 1'b1;
         end else if (boundary) begin
            soft_y_q <= 1'b0;
         end
      end
   end

   // Fault pins: filter, event flag, request latch and disable latch
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_fault
         wire lvl_ok;
         wire rel;
         fault_filter u_filter (
            .clk_i   (MCLK_I),
            .rst_i   (RESET_I),
            .pin_i   (FAULT_I[i]),
            .level_o (level[i]),
            .state_o (pin_state[i]),
            .rise_o  (rise[i])
         );
         // In manual mode pins 1 and 3 release at any level, pins 2 and 4 only when low
         assign lvl_ok = (i % 2 == 0) ? 1'b1 : ~level[i];
         // Automatic ignores the flag entirely
         assign rel = boundary & (auto_mode_q[i] ? ~pin_state[i] : (~flag_q[i] & lvl_ok));
         always @(posedge MCLK_I or posedge RESET_I) begin
            if (RESET_I) begin
               flag_q[i]      <= 1'b0;
               FAULT_IRQ_O[i] <= 1'b0;
               fdis_q[i]      <= 1'b0;
            end else begin
               flag_q[i] <= rise[i] | (flag_q[i] & ~ack[i]);
               FAULT_IRQ_O[i] <= irq_en_q[i] & (rise[i] | (FAULT_IRQ_O[i] & ~ack[i]));
               if (rise[i]) begin
                  fdis_q[i] <= 1'b1;
               end else if (rel) begin
                  fdis_q[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign bank_x  = fdis_q[0] | fdis_q[1] | soft_x_q;
   assign bank_y  = fdis_q[2] | fdis_q[3] | soft_y_q;
   assign out_dis = ({6{bank_x}} & map_q[`MAP_X_LSB +: 6]) |
                    ({6{bank_y}} & map_q[`MAP_Y_LSB +: 6]);

   // Independent mode takes override bits or the generator directly
   assign act_d = (compl_q ? cmp_act : (src_ovr_q ? ovr_bits_q : GEN_ACTIVE_I)) &
                  ~out_dis;

   // Index 0 is output 1, a top output
   assign neg_mask = {bot_neg_q, top_neg_q, bot_neg_q, top_neg_q,
                      bot_neg_q, top_neg_q};

   // Pins driven while enabled or overridden; inactive level follows polarity
   always @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PWM_O    <= 6'h00;
         PWM_OE_O <= 6'h00;
      end else begin
         PWM_O    <= act_d ^ neg_mask;
         PWM_OE_O <= {6{PWM_ENABLE_O | ovr_en_q}};
      end
   end

endmodule

`default_nettype wire

// ==== testbench/pwm_output_stage_properties.sv ====
/* Port checker for the PWM output stage.
   Assumes binding to the stage's top ports; reset is async high. */
`default_nettype none
module pwm_output_stage_properties (
   input wire logic        MCLK_I,
   input wire logic        RESET_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        PWM_ENABLE_O,
   input wire logic [5:0]  PWM_OE_O,
   input wire logic [3:0]  FAULT_I,
   input wire logic [3:0]  FAULT_IRQ_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   wire setup = PSEL_I && !PENABLE_I;
   chk_ready_after: assert property (setup |=> PREADY_O)
      else $error("ready missing after setup");
   chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready held too long");
   chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   chk_data_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
      else $error("read data outside access");
   chk_err_unmapped: assert property (setup && PADDR_I > 8'h18 |=> PSLVERR_O)
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (setup && PADDR_I <= 8'h18 && PADDR_I[1:0] == 2'h0
      |=> !PSLVERR_O) else $error("mapped access refused");
   chk_oe_follow: assert property (PWM_ENABLE_O [*2] |-> PWM_OE_O == 6'h3F)
      else $error("pins not driven while enabled");
   chk_irq_quiet: assert property ((!FAULT_I[0]) [*8] |=> !$rose(FAULT_IRQ_O[0]))
      else $error("request without filtered fault");
   chk_irq_hold: assert property ($fell(FAULT_IRQ_O[0]) |->
      $past(PSEL_I && PENABLE_I && PWRITE_I)) else $error("request dropped without write");
   cover property ($rose(FAULT_IRQ_O[0]));
   cover property (PSLVERR_O);
   cover property ($rose(PWM_OE_O[0]));
endmodule
bind pwm_output_stage pwm_output_stage_properties props_i (.MCLK_I(MCLK_I),
   .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .PWM_ENABLE_O(PWM_ENABLE_O), .PWM_OE_O(PWM_OE_O), .FAULT_I(FAULT_I),
   .FAULT_IRQ_O(FAULT_IRQ_O));
`default_nettype wire

// ==== testbench/inverter_model.sv ====
/* Fault sensing of the external inverter drive.
   Assumes the bench commands each trip; pins are driven at all times. */
`default_nettype none
module inverter_model (
   // Clock and command
   input  wire logic       clk_i,
   input  wire logic [3:0] trip_i,
   // Fault pins, high means fault
   output var  logic [3:0] fault_o
);
   initial fault_o = 4'h0;
   // Comparator output settles a cycle after the trip; held for many samples
   always @(posedge clk_i) begin
      fault_o <= trip_i;
   end
endmodule
`default_nettype wire

// ==== testbench/pwm_output_polarity_fault_disable_tb.sv ====
/* Self-checking bench for the PWM output stage.
   Assumes the drive model and the checker are compiled before it. */
`default_nettype none
module pwm_output_polarity_fault_disable_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst, psel, penable, pwrite, cstart;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [5:0]  gen;
   logic [3:0]  trip, cyc;
   logic        watch_gen;
   logic [5:0]  gen_d;
   wire         pready, pslverr, pwm_en;
   wire  [31:0] prdata;
   wire  [5:0]  pwm, pwm_oe;
   wire  [3:0]  fault, irq;
   logic [32:0] exp_q[$];
   int          n_errors = 0, tests_run = 0, seed = 3;
   pwm_output_stage pwm_output_stage_i (.MCLK_I(mclk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .GEN_ACTIVE_I(gen),
      .CYCLE_START_I(cstart), .PWM_ENABLE_O(pwm_en), .FAULT_I(fault), .PWM_O(pwm),
      .PWM_OE_O(pwm_oe), .FAULT_IRQ_O(irq));
   inverter_model inverter_model_i (.clk_i(mclk), .trip_i(trip), .fault_o(fault));
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {gen, cstart, trip, cyc, mclk} = 16'h0;
      watch_gen = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Generator keeps running underneath the output stage
   always @(posedge mclk) begin
      gen <= 6'($random(seed));
      cstart <= (cyc == 4'hF);
      cyc <= cyc + 4'h1;
   end
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         check({pslverr, prdata}, exp_q.pop_front());
   end
   // Generator path: pins follow last cycle's channel levels with top polarity negative
   always @(posedge mclk) begin
      gen_d <= gen;
      if (watch_gen)
         check({21'h0, pwm_oe, pwm}, {21'h0, 6'h3F, gen_d ^ 6'h15});
   end
   task automatic complete_run;
      if (exp_q.size() != 0) n_errors++;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One idle edge after each transfer keeps strobes from being driven twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (!pready) @(posedge mclk);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      complete_run();
   end
   initial begin
      logic [5:0] b, a;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(8'h0C, {1'b0, 32'h0FFF});
      rd(8'h14, {1'b0, 32'h0});
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h2);
      rd(8'h00, {1'b0, 32'h5});
      wr(8'h0C, 32'hC03);
      wr(8'h0C, 32'hFFF);
      rd(8'h0C, {1'b0, 32'h1C03});
      $display("test write once done");
      wr(8'h08, 32'h40);
      for (int i = 0; i < 6; i++) begin
         b = (i == 0) ? 6'h3F : 6'($random(seed));
         if (i == 3) wr(8'h04, 32'h0302);
         a = (i < 3) ? b : ((b & 6'h15) | (b & 6'h2A & ~((b & 6'h15) << 1)));
         wr(8'h08, {25'h0, 1'b1, b});
         idle(10);
         rd(8'h18, {21'h0, 6'h0, a ^ 6'h15});
      end
      $display("test override done");
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h7F);
      wr(8'h10, 32'h11);
      trip <= 4'h1;
      idle(12);
      check({29'h0, irq}, 33'h1);
      rd(8'h14, {1'b0, 32'h11});
      wr(8'h14, 32'h100);
      idle(4);
      check({29'h0, irq}, 33'h0);
      rd(8'h18, {1'b0, 32'h0E9});
      rd(8'h14, {1'b0, 32'h01});
      trip <= 4'h0;
      idle(12);
      rd(8'h14, {1'b0, 32'h0});
      rd(8'h18, {1'b0, 32'h02A});
      $display("test automatic fault done");
      wr(8'h10, 32'h0);
      trip <= 4'h2;
      idle(12);
      wr(8'h14, 32'h200);
      idle(4);
      rd(8'h18, {1'b0, 32'h0E9});
      trip <= 4'h4;
      idle(12);
      rd(8'h18, {1'b0, 32'hC1A});
      wr(8'h14, 32'h400);
      idle(4);
      rd(8'h18, {1'b0, 32'h02A});
      trip <= 4'h0;
      $display("test manual fault done");
      for (int k = 0; k < 2; k++) begin
         wr(8'h04, k ? 32'h8 : 32'h4);
         idle(3);
         rd(8'h18, {1'b0, k ? 32'hC1A : 32'h0E9});
      end
      wr(8'h04, 32'h0);
      idle(4);
      rd(8'h18, {1'b0, 32'h02A});
      rd(8'h40, {1'b1, 32'h0});
      $display("test soft disable done");
      wr(8'h08, 32'h40);
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h1);
      idle(20);
      rd(8'h04, {1'b0, 32'h1});
      watch_gen <= 1'b1;
      idle(20);
      watch_gen <= 1'b0;
      $display("test generator path done");
      complete_run();
   end
endmodule
`default_nettype wire
